//--- verilog/xma_pkg.sv
// Notes on behaviour
// - Far move to accumulator loads the memory byte; flags stay unchanged.
// - Far move to memory writes the accumulator into the byte; flags unchanged.
// - Far OR to accumulator stores acc OR byte in acc; only zero flag.
// - Far OR to memory stores acc OR byte in memory; only zero flag.
// - Rotate left, bit 7 into bit 0, no flags; acc variant spares memory.
// - Rotate left through carry: carry into bit 0, bit 7 to carry.
// - Rotate right, bit 0 into bit 7, no flags; acc variant spares memory.
// - Rotate right through carry: carry into bit 7, bit 0 to carry.
// - Subtract with borrow: acc minus byte minus inverted carry; six flags.
// - Memory variant of subtract with borrow stores result in memory byte.
// - In every subtraction carry is cleared if negative, set otherwise.
// - Skip instructions add one dummy cycle; three cycles; false continues.
// - Decrement-and-skip writes byte minus one back; skips when zero.
// - Acc decrement-and-skip puts byte minus one in acc; memory unchanged.
// - Far set writes all ones into the byte; flags unchanged.
// - Far set-bit forces one selected bit; other bits and flags kept.
// - Increment-and-skip writes byte plus one back; skips when zero.
// - Acc increment-and-skip puts byte plus one in acc; memory unchanged.
// - Skip-if-bit-set skips when the selected bit is one; no flags.
// - Skip-if-nonzero rewrites the byte unchanged; skips when nonzero.
// - Far subtract puts acc minus byte in acc; six flags updated.
// - Memory far subtract stores acc minus byte in memory byte.
// - Every instruction here addresses any data memory section directly.
package xma_pkg;
   localparam int        ADDR_W   = 16;
   localparam int        DATA_W   = 8;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ONE_BIT  = 8'h01;
   localparam logic [7:0] ZERO_B   = 8'h00;

   typedef enum logic [4:0] {
      far_move_to_acc               = 5'b00000,
      far_move                      = 5'b00001,
      far_or_to_acc                 = 5'b00010,
      far_or_to_mem                 = 5'b00011,
      far_rotate_left               = 5'b00100,
      far_rotate_left_to_acc        = 5'b00101,
      far_rotate_left_carry         = 5'b00110,
      far_rotate_left_carry_to_acc  = 5'b00111,
      far_rotate_right              = 5'b01000,
      far_rotate_right_to_acc       = 5'b01001,
      far_rotate_right_carry        = 5'b01010,
      far_rotate_right_carry_to_acc = 5'b01011,
      far_subtract_borrow           = 5'b01100,
      far_subtract_borrow_to_mem    = 5'b01101,
      far_decrement_skip            = 5'b01110,
      far_decrement_skip_to_acc     = 5'b01111,
      far_set                       = 5'b10000,
      far_set_bit                   = 5'b10001,
      far_increment_skip            = 5'b10010,
      far_increment_skip_to_acc     = 5'b10011,
      far_skip_bit_set              = 5'b10100,
      far_skip_nonzero              = 5'b10101,
      far_subtract                  = 5'b10110,
      far_subtract_to_mem           = 5'b10111
   } xma_op_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_EXEC  = 2'b10,
      ST_DUMMY = 2'b11
   } xma_state_e;

   typedef struct packed {
      xma_op_e             op;
      logic [ADDR_W-1:0]   addr;
      logic [2:0]          bitSel;
   } xma_cmd_s;

   typedef struct packed {
      logic signRangeExceeded;
      logic zero;
      logic halfCarry;
      logic carry;
      logic signedCarry;
      logic chainedZero;
   } xma_flags_s;

   localparam xma_flags_s FLAGS_RST = '0;
endpackage

//--- verilog/xma_unit.sv
`timescale 1ns/1ps
module xma_unit (
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   input  wire logic                      cmdValid,
   input  wire xma_pkg::xma_cmd_s         cmd,
   output wire logic                      cmdReady,
   output logic                           memRdEn,
   output logic                           memWrEn,
   output logic [xma_pkg::ADDR_W-1:0]     memAddr,
   output logic [xma_pkg::DATA_W-1:0]     memWrData,
   input  wire logic [xma_pkg::DATA_W-1:0] memRdData,
   input  wire logic                      accLoad,
   input  wire logic [xma_pkg::DATA_W-1:0] accLoadData,
   input  wire logic                      flagLoad,
   input  wire xma_pkg::xma_flags_s       flagLoadData,
   output logic [xma_pkg::DATA_W-1:0]     acc,
   output xma_pkg::xma_flags_s            flags,
   output logic                           instDone,
   output logic                           instSkip
);
   import xma_pkg::*;

   xma_state_e state_r;
   xma_cmd_s   cmd_r;
   logic       skipPend_r;

   wire logic take = cmdValid && (state_r == ST_IDLE);
   assign cmdReady = (state_r == ST_IDLE);
   wire logic inExec = (state_r == ST_EXEC);

   wire logic [7:0] rd = memRdData;
   wire logic [7:0] a  = acc;
   wire xma_op_e    op = cmd_r.op;

   // Shared subtractor: a + ~m + cin, carry out is the inverted borrow
   wire logic isSbc = (op == far_subtract_borrow) ||
                      (op == far_subtract_borrow_to_mem);
   wire logic subCin = isSbc ? flags.carry : 1'b1;
   wire logic [8:0] subSum = {1'b0, a} + {1'b0, ~rd} + {8'h00, subCin};
   wire logic [4:0] subLow = {1'b0, a[3:0]} + {1'b0, ~rd[3:0]}
                             + {4'h0, subCin};
   wire logic [7:0] subRes = subSum[7:0];
   wire logic subOv = (a[7] != rd[7]) && (subRes[7] != a[7]);
   wire logic subZ  = (subRes == ZERO_B);

   wire logic [7:0] orRes  = a | rd;
   wire logic [7:0] decRes = rd - ONE_BIT;
   wire logic [7:0] incRes = rd + ONE_BIT;
   wire logic [7:0] bitRes = rd | (ONE_BIT << cmd_r.bitSel);

   logic [7:0] res;
   logic       toAcc;
   logic       toMem;
   logic       isSkip;
   logic       skipCond;
   xma_flags_s flgNxt;

   always_comb begin
      res      = rd;
      toAcc    = 1'b0;
      toMem    = 1'b0;
      isSkip   = 1'b0;
      skipCond = 1'b0;
      flgNxt   = flags;
      unique case (op)
         far_move_to_acc: begin
            toAcc = 1'b1;
         end
         far_move: begin
            res   = a;
            toMem = 1'b1;
         end
         far_or_to_acc, far_or_to_mem: begin
            res         = orRes;
            toAcc       = (op == far_or_to_acc);
            toMem       = (op == far_or_to_mem);
            flgNxt.zero = (orRes == ZERO_B);
         end
         far_rotate_left, far_rotate_left_to_acc: begin
            res   = {rd[6:0], rd[7]};
            toAcc = (op == far_rotate_left_to_acc);
            toMem = (op == far_rotate_left);
         end
         far_rotate_left_carry, far_rotate_left_carry_to_acc: begin
            res          = {rd[6:0], flags.carry};
            flgNxt.carry = rd[7];
            toAcc        = (op == far_rotate_left_carry_to_acc);
            toMem        = (op == far_rotate_left_carry);
         end
         far_rotate_right, far_rotate_right_to_acc: begin
            res   = {rd[0], rd[7:1]};
            toAcc = (op == far_rotate_right_to_acc);
            toMem = (op == far_rotate_right);
         end
         far_rotate_right_carry, far_rotate_right_carry_to_acc: begin
            res          = {flags.carry, rd[7:1]};
            flgNxt.carry = rd[0];
            toAcc        = (op == far_rotate_right_carry_to_acc);
            toMem        = (op == far_rotate_right_carry);
         end
         far_subtract_borrow, far_subtract_borrow_to_mem,
         far_subtract, far_subtract_to_mem: begin
            res   = subRes;
            toAcc = (op == far_subtract_borrow) || (op == far_subtract);
            toMem = !toAcc;
            flgNxt.signRangeExceeded = subOv;
            flgNxt.zero              = subZ;
            flgNxt.halfCarry         = subLow[4];
            flgNxt.carry             = subSum[8];
            flgNxt.signedCarry       = subOv ^ subRes[7];
            // Borrow chain keeps zero only if the lower bytes were zero
            flgNxt.chainedZero = isSbc ? (subZ && flags.chainedZero) : subZ;
         end
         far_decrement_skip, far_decrement_skip_to_acc: begin
            res      = decRes;
            isSkip   = 1'b1;
            skipCond = (decRes == ZERO_B);
            toMem    = (op == far_decrement_skip);
            toAcc    = (op == far_decrement_skip_to_acc);
         end
         far_set: begin
            res   = ALL_ONES;
            toMem = 1'b1;
         end
         far_set_bit: begin
            res   = bitRes;
            toMem = 1'b1;
         end
         far_increment_skip, far_increment_skip_to_acc: begin
            res      = incRes;
            isSkip   = 1'b1;
            skipCond = (incRes == ZERO_B);
            toMem    = (op == far_increment_skip);
            toAcc    = (op == far_increment_skip_to_acc);
         end
         far_skip_bit_set: begin
            isSkip   = 1'b1;
            skipCond = rd[cmd_r.bitSel];
         end
         far_skip_nonzero: begin
            // Rewrite of the same byte mirrors the read-modify-write slot
            isSkip   = 1'b1;
            toMem    = 1'b1;
            skipCond = (rd != ZERO_B);
         end
         // Spare codes act as a plain no-op: no write, flags kept
         default: ;
      endcase
   end

   // Sequencer: read, execute, and a dummy slot only for skips
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r    <= ST_IDLE;
         cmd_r      <= '0;
         skipPend_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (take) begin
                  cmd_r   <= cmd;
                  state_r <= ST_READ;
               end
            end
            ST_READ: state_r <= ST_EXEC;
            ST_EXEC: begin
               skipPend_r <= skipCond;
               state_r    <= isSkip ? ST_DUMMY : ST_IDLE;
            end
            ST_DUMMY: state_r <= ST_IDLE;
         endcase
      end
   end

   // Full address is passed through, so any memory section is reachable
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         memAddr <= '0;
         memRdEn <= 1'b0;
      end else begin
         memRdEn <= take;
         if (take) begin
            memAddr <= cmd.addr;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         memWrEn   <= 1'b0;
         memWrData <= ZERO_B;
      end else begin
         memWrEn <= inExec && toMem;
         if (inExec && toMem) begin
            memWrData <= res;
         end
      end
   end

   // An acc-writing op wins over an acc preload in the same cycle; execution always wins for flags
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         acc   <= ZERO_B;
         flags <= FLAGS_RST;
      end else begin
         if (inExec && toAcc) begin
            acc <= res;
         end else if (accLoad) begin
            acc <= accLoadData;
         end
         if (inExec) begin
            flags <= flgNxt;
         end else if (flagLoad) begin
            flags <= flagLoadData;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         instDone <= 1'b0;
         instSkip <= 1'b0;
      end else begin
         instDone <= (inExec && !isSkip) || (state_r == ST_DUMMY);
         instSkip <= (state_r == ST_DUMMY) && skipPend_r;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_move_acc_load: assert property (
      inExec && op == far_move_to_acc && !accLoad
      |=> acc == $past(memRdData) && flags == $past(flags))
      else $error("move to acc wrong");

   a_move_mem_write: assert property (
      inExec && op == far_move
      |=> memWrEn && memWrData == $past(acc) && flags == $past(flags))
      else $error("move to mem wrong");

   a_or_zero_only: assert property (
      inExec && op == far_or_to_acc
      |=> acc == ($past(acc) | $past(memRdData))
          && flags.zero == (acc == ZERO_B)
          && flags.carry == $past(flags.carry))
      else $error("or to acc wrong");

   a_rotate_left_mem: assert property (
      inExec && op == far_rotate_left
      |=> memWrEn
          && memWrData == {$past(memRdData[6:0]), $past(memRdData[7])})
      else $error("rotate left wrong");

   a_rlc_carry_out: assert property (
      inExec && op == far_rotate_left_carry
      |=> flags.carry == $past(memRdData[7])
          && memWrData[0] == $past(flags.carry))
      else $error("rotate left carry wrong");

   a_rrc_carry_out: assert property (
      inExec && op == far_rotate_right_carry_to_acc && !accLoad
      |=> flags.carry == $past(memRdData[0])
          && acc[7] == $past(flags.carry) && !memWrEn)
      else $error("rotate right carry wrong");

   a_sub_carry_sense: assert property (
      inExec && op == far_subtract
      |=> flags.carry == ($past(acc) >= $past(memRdData)))
      else $error("subtract carry wrong");

   a_set_all_ones: assert property (
      inExec && op == far_set |=> memWrEn && memWrData == ALL_ONES)
      else $error("set byte wrong");

   a_skip_three_cyc: assert property (
      state_r == ST_READ |=> isSkip |=> !instDone ##1 instDone)
      else $error("skip timing wrong");

   a_plain_two_cyc: assert property (
      state_r == ST_READ ##1 !isSkip |=> instDone && !instSkip)
      else $error("plain timing wrong");

   a_dec_skip_cond: assert property (
      inExec && op == far_decrement_skip
      |=> memWrEn ##1 instDone
          && instSkip == ($past(memRdData, 2) == ONE_BIT))
      else $error("decrement skip wrong");

   a_deca_no_write: assert property (
      inExec && op == far_decrement_skip_to_acc && !accLoad
      |=> !memWrEn && acc == $past(memRdData) - ONE_BIT)
      else $error("decrement to acc wrong");

   a_or_mem_zero: assert property (
      inExec && op == far_or_to_mem
      |=> memWrEn && memWrData == ($past(acc) | $past(memRdData))
          && flags.zero == (memWrData == ZERO_B)
          && flags.carry == $past(flags.carry))
      else $error("or to mem wrong");

   a_sbc_chain_zero: assert property (
      inExec && op == far_subtract_borrow
      |=> acc == $past(acc) - $past(memRdData) - {7'h00, ~$past(flags.carry)}
          && flags.chainedZero
             == (acc == ZERO_B && $past(flags.chainedZero)))
      else $error("subtract borrow wrong");

   a_sbcm_to_mem: assert property (
      inExec && op == far_subtract_borrow_to_mem && !accLoad
      |=> memWrEn && acc == $past(acc)
          && memWrData == $past(acc) - $past(memRdData)
             - {7'h00, ~$past(flags.carry)})
      else $error("subtract borrow to mem wrong");

   a_sub_mem_result: assert property (
      inExec && op == far_subtract_to_mem && !accLoad
      |=> memWrEn && acc == $past(acc)
          && memWrData == $past(acc) - $past(memRdData)
          && flags.carry == ($past(acc) >= $past(memRdData)))
      else $error("subtract to mem wrong");

   a_set_bit_only: assert property (
      inExec && op == far_set_bit
      |=> memWrEn && memWrData[cmd_r.bitSel]
          && ((memWrData ^ $past(memRdData)) & ~(ONE_BIT << cmd_r.bitSel))
             == ZERO_B && flags == $past(flags))
      else $error("set bit wrong");

   a_inc_skip_cond: assert property (
      inExec && op == far_increment_skip
      |=> memWrEn && memWrData == $past(memRdData) + ONE_BIT
          && flags == $past(flags)
          ##1 instDone && instSkip == (memWrData == ZERO_B))
      else $error("increment skip wrong");

   a_inca_no_write: assert property (
      inExec && op == far_increment_skip_to_acc
      |=> !memWrEn && acc == $past(memRdData) + ONE_BIT
          ##1 instDone && instSkip == ($past(acc) == ZERO_B))
      else $error("increment to acc wrong");

   a_bit_skip_cond: assert property (
      inExec && op == far_skip_bit_set
      |=> !memWrEn && flags == $past(flags)
          ##1 instDone && instSkip == $past(memRdData[cmd_r.bitSel], 2))
      else $error("skip bit set wrong");

   a_nonzero_rewrite: assert property (
      inExec && op == far_skip_nonzero
      |=> memWrEn && memWrData == $past(memRdData) && flags == $past(flags)
          ##1 instDone && instSkip == (memWrData != ZERO_B))
      else $error("skip nonzero wrong");
endmodule

//--- sim/xma_mem_model.sv
`timescale 1ns/1ps
module xma_mem_model (
   input  wire logic                       sys_clk,
   input  wire logic                       memRdEn,
   input  wire logic                       memWrEn,
   input  wire logic [xma_pkg::ADDR_W-1:0] memAddr,
   input  wire logic [xma_pkg::DATA_W-1:0] memWrData,
   output logic [xma_pkg::DATA_W-1:0]      memRdData
);
   import xma_pkg::*;
   // Low address byte only; upper bits are checked at the port instead
   logic [7:0] mem [0:255];
   logic [7:0] rdQ = 8'h00;
   assign memRdData = rdQ;
   always @(posedge sys_clk) begin
      if (memWrEn)
         mem[memAddr[7:0]] <= memWrData;
      // Outside the read slot the bus toggles so stale data never matches
      if (memRdEn)
         rdQ <= mem[memAddr[7:0]];
      else
         rdQ <= ~rdQ;
   end
endmodule

//--- sim/extended_mem_alu_ops_tb.sv
`timescale 1ns/1ps
module extended_mem_alu_ops_tb;
   import xma_pkg::*;
   logic sys_clk = 1'h0, resetn = 1'h0, cmdValid = 1'h0;
   logic accLoad = 1'h0, flagLoad = 1'h0;
   xma_cmd_s cmd = '0;
   xma_flags_s flagLoadData = '0, flags;
   logic [7:0] accLoadData = 8'h00, memRdData, memWrData, acc;
   logic [15:0] memAddr;
   logic cmdReady, memRdEn, memWrEn, instDone, instSkip;
   logic [7:0] gotAcc, gotMem;
   logic [5:0] gotFlags;
   logic gotSkip;
   int gotCyc, errorCnt = 0, totalChecks = 0, cycCnt = 0;

   xma_unit dut_u (.sys_clk(sys_clk), .resetn(resetn), .cmdValid(cmdValid),
      .cmd(cmd), .cmdReady(cmdReady), .memRdEn(memRdEn), .memWrEn(memWrEn),
      .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
      .accLoad(accLoad), .accLoadData(accLoadData), .flagLoad(flagLoad),
      .flagLoadData(flagLoadData), .acc(acc), .flags(flags),
      .instDone(instDone), .instSkip(instSkip));
   xma_mem_model mem_u (.sys_clk(sys_clk), .memRdEn(memRdEn),
      .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
      .memRdData(memRdData));

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic testDone();
      if (errorCnt == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the scenarios need
   always @(posedge sys_clk) begin
      cycCnt++;
      if (cycCnt == 20000) begin
         errorCnt++;
         testDone();
      end
   end

   task automatic chkv(input string nm, input logic [15:0] e, g);
      totalChecks++;
      if (g !== e) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkf(input logic [5:0] e, g);
      totalChecks++;
      if (g !== e) begin
         errorCnt++;
         $display("ERROR flags expected %b seen %b", e, g);
      end
   endtask

   task automatic run(input xma_op_e op, input logic [15:0] ad,
                      input logic [2:0] bs, input logic [7:0] m, a,
                      input logic [5:0] f);
      int n;
      mem_u.mem[ad[7:0]] = m;
      @(posedge sys_clk);
      accLoad <= 1'h1;
      accLoadData <= a;
      flagLoad <= 1'h1;
      flagLoadData <= xma_flags_s'(f);
      @(posedge sys_clk);
      accLoad <= 1'h0;
      flagLoad <= 1'h0;
      cmdValid <= 1'h1;
      cmd <= xma_cmd_s'{op, ad, bs};
      @(posedge sys_clk);
      cmdValid <= 1'h0;
      #1;
      chkv("memAddr", ad, memAddr);
      n = 1;
      while (instDone !== 1'h1 && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      gotCyc = n;
      gotSkip = instSkip;
      gotAcc = acc;
      gotFlags = flags;
      // Plain ops write back on the edge after completion, skips on the completion edge
      @(posedge sys_clk);
      #1;
      gotMem = mem_u.mem[ad[7:0]];
   endtask

   task automatic ex(input logic [7:0] ea, em, input logic [5:0] ef,
                     input logic es, input int cy);
      chkv("acc", ea, gotAcc);
      chkv("mem", em, gotMem);
      chkf(ef, gotFlags);
      chkv("skip", es, gotSkip);
      chkv("cycles", 16'(cy), 16'(gotCyc));
   endtask

   task automatic t_reset();
      chkv("acc", 8'h00, acc);
      chkf(6'h00, flags);
      chkv("ready", 1'h1, cmdReady);
   endtask

   task automatic t_move();
      run(far_move_to_acc, 16'h1234, 3'h0, 8'h5A, 8'hC3, 6'h2A);
      ex(8'h5A, 8'h5A, 6'h2A, 1'h0, 3);
      run(far_move, 16'hFE34, 3'h0, 8'h5A, 8'hC3, 6'h15);
      ex(8'hC3, 8'hC3, 6'h15, 1'h0, 3);
      run(far_or_to_acc, 16'h8001, 3'h0, 8'h0F, 8'h30, 6'h15);
      ex(8'h3F, 8'h0F, 6'h05, 1'h0, 3);
      run(far_or_to_mem, 16'h4002, 3'h0, 8'h00, 8'h00, 6'h2A);
      ex(8'h00, 8'h00, 6'h3A, 1'h0, 3);
   endtask

   task automatic t_rot();
      run(far_rotate_left, 16'h0110, 3'h0, 8'h96, 8'h11, 6'h15);
      ex(8'h11, 8'h2D, 6'h15, 1'h0, 3);
      run(far_rotate_left_to_acc, 16'h0211, 3'h0, 8'h96, 8'h11, 6'h15);
      ex(8'h2D, 8'h96, 6'h15, 1'h0, 3);
      run(far_rotate_left_carry, 16'h0312, 3'h0, 8'h96, 8'h11, 6'h2A);
      ex(8'h11, 8'h2C, 6'h2E, 1'h0, 3);
      run(far_rotate_left_carry_to_acc, 16'h0413, 3'h0, 8'h69, 8'h11, 6'h15);
      ex(8'hD3, 8'h69, 6'h11, 1'h0, 3);
      run(far_rotate_right, 16'h0514, 3'h0, 8'h96, 8'h11, 6'h15);
      ex(8'h11, 8'h4B, 6'h15, 1'h0, 3);
      run(far_rotate_right_to_acc, 16'h0615, 3'h0, 8'h69, 8'h11, 6'h15);
      ex(8'hB4, 8'h69, 6'h15, 1'h0, 3);
      run(far_rotate_right_carry, 16'h0716, 3'h0, 8'h69, 8'h11, 6'h2A);
      ex(8'h11, 8'h34, 6'h2E, 1'h0, 3);
      run(far_rotate_right_carry_to_acc, 16'h0817, 3'h0, 8'h96, 8'h11, 6'h15);
      ex(8'hCB, 8'h96, 6'h11, 1'h0, 3);
   endtask

   // Flags {ov,z,ac,c,sc,cz} worked out by hand per operand pair
   task automatic t_sub();
      run(far_subtract, 16'hC020, 3'h0, 8'h70, 8'h50, 6'h15);
      ex(8'hE0, 8'h70, 6'h0A, 1'h0, 3);
      run(far_subtract_to_mem, 16'hC121, 3'h0, 8'h01, 8'h80, 6'h2A);
      ex(8'h80, 8'h7F, 6'h26, 1'h0, 3);
      run(far_subtract_borrow, 16'hC222, 3'h0, 8'h0F, 8'h10, 6'h2A);
      ex(8'h00, 8'h0F, 6'h14, 1'h0, 3);
      run(far_subtract_borrow_to_mem, 16'hC323, 3'h0, 8'h10, 8'h10, 6'h15);
      ex(8'h10, 8'h00, 6'h1D, 1'h0, 3);
   endtask

   task automatic t_skip();
      run(far_decrement_skip, 16'h2030, 3'h0, 8'h01, 8'h44, 6'h2A);
      ex(8'h44, 8'h00, 6'h2A, 1'h1, 4);
      run(far_decrement_skip, 16'h2131, 3'h0, 8'h00, 8'h44, 6'h15);
      ex(8'h44, 8'hFF, 6'h15, 1'h0, 4);
      run(far_decrement_skip_to_acc, 16'h2232, 3'h0, 8'h01, 8'h44, 6'h2A);
      ex(8'h00, 8'h01, 6'h2A, 1'h1, 4);
      run(far_increment_skip, 16'h2333, 3'h0, 8'hFF, 8'h44, 6'h15);
      ex(8'h44, 8'h00, 6'h15, 1'h1, 4);
      run(far_increment_skip_to_acc, 16'h2434, 3'h0, 8'h7F, 8'h44, 6'h2A);
      ex(8'h80, 8'h7F, 6'h2A, 1'h0, 4);
      run(far_skip_bit_set, 16'h2535, 3'h5, 8'h20, 8'h44, 6'h15);
      ex(8'h44, 8'h20, 6'h15, 1'h1, 4);
      run(far_skip_bit_set, 16'h2636, 3'h4, 8'hEF, 8'h44, 6'h2A);
      ex(8'h44, 8'hEF, 6'h2A, 1'h0, 4);
      run(far_skip_nonzero, 16'h2737, 3'h0, 8'h00, 8'h44, 6'h15);
      ex(8'h44, 8'h00, 6'h15, 1'h0, 4);
      run(far_skip_nonzero, 16'h2838, 3'h0, 8'h80, 8'h44, 6'h2A);
      ex(8'h44, 8'h80, 6'h2A, 1'h1, 4);
   endtask

   task automatic t_set();
      run(far_set, 16'hF040, 3'h0, 8'h12, 8'h44, 6'h2A);
      ex(8'h44, 8'hFF, 6'h2A, 1'h0, 3);
      run(far_set_bit, 16'hF141, 3'h7, 8'h00, 8'h44, 6'h15);
      ex(8'h44, 8'h80, 6'h15, 1'h0, 3);
      run(far_set_bit, 16'hF242, 3'h0, 8'hFE, 8'h44, 6'h2A);
      ex(8'h44, 8'hFF, 6'h2A, 1'h0, 3);
   endtask

   // Request held while busy must be ignored; preload in the
   // execute slot wins for acc here but always loses for flags
   task automatic t_busy();
      mem_u.mem[8'h52] = 8'h33;
      mem_u.mem[8'h53] = 8'h77;
      @(posedge sys_clk);
      flagLoad <= 1'h1;
      flagLoadData <= xma_flags_s'(6'h15);
      cmdValid <= 1'h1;
      cmd <= xma_cmd_s'{far_increment_skip, 16'h0052, 3'h0};
      @(posedge sys_clk);
      flagLoad <= 1'h0;
      cmd <= xma_cmd_s'{far_set, 16'h0053, 3'h0};
      @(posedge sys_clk);
      cmdValid <= 1'h0;
      accLoad <= 1'h1;
      accLoadData <= 8'h9C;
      flagLoad <= 1'h1;
      flagLoadData <= xma_flags_s'(6'h2A);
      @(posedge sys_clk);
      accLoad <= 1'h0;
      flagLoad <= 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      chkv("acc", 8'h9C, acc);
      chkf(6'h15, flags);
      chkv("mem", 8'h34, mem_u.mem[8'h52]);
      chkv("mem", 8'h77, mem_u.mem[8'h53]);
      chkv("ready", 1'h1, cmdReady);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      #1;
      t_reset();
      @(posedge sys_clk);
      resetn <= 1'h1;
      t_move();
      t_rot();
      t_sub();
      t_skip();
      t_set();
      t_busy();
      testDone();
   end
endmodule
